// *** design/vsc_pkg.sv ***
// Shared constants and types for the voltage setpoint controller
package vsc_pkg;
   // ==========================================================
   // Register indices
   localparam logic [3:0] VSC_REG_CFG    = 4'h0;
   localparam logic [3:0] VSC_REG_BOOT1  = 4'h1;
   localparam logic [3:0] VSC_REG_BOOT2  = 4'h2;
   localparam logic [3:0] VSC_REG_STBY   = 4'h3;
   localparam logic [3:0] VSC_REG_VMIN   = 4'h4;
   localparam logic [3:0] VSC_REG_VMAX   = 4'h5;
   localparam logic [3:0] VSC_REG_OFFS   = 4'h6;
   localparam logic [3:0] VSC_REG_RATE1  = 4'h7;
   localparam logic [3:0] VSC_REG_RATE2  = 4'h8;
   localparam logic [3:0] VSC_REG_TONR   = 4'h9;
   localparam logic [3:0] VSC_REG_PGON   = 4'hA;
   localparam logic [3:0] VSC_REG_OCN    = 4'hB;
   localparam logic [3:0] VSC_REG_OCL    = 4'hC;
   localparam logic [3:0] VSC_REG_STATUS = 4'hD;
   // ==========================================================
   // Configuration field positions
   localparam int VSC_CFG_SWAP  = 0;
   localparam int VSC_CFG_RES10 = 1;
   localparam int VSC_CFG_PWM   = 2;
   localparam int VSC_CFG_PH2   = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0] VSC_RST_CFG  = 8'h00;
   localparam logic [7:0] VSC_RST_BOOT = 8'hB4;
   localparam logic [7:0] VSC_RST_STBY = 8'h64;
   localparam logic [7:0] VSC_RST_VMIN = 8'h00;
   localparam logic [7:0] VSC_RST_VMAX = 8'hFF;
   localparam logic [7:0] VSC_RST_OFFS = 8'h00;
   localparam logic [7:0] VSC_RST_RATE = 8'h03;
   localparam logic [7:0] VSC_RST_PGON = 8'h3C;
   localparam logic [7:0] VSC_RST_OC   = 8'h80;
   // ==========================================================
   // Voltage encodings, 1.25 mV per internal unit
   localparam logic [11:0] VSC_SVID_TOP   = 12'h4D8;
   localparam logic [11:0] VSC_PWM_BASE   = 12'h1E0;
   localparam logic [7:0]  VSC_OFF_CODE   = 8'hF7;
   localparam logic [8:0]  VSC_TEL_OFF    = 9'h1F7;
   localparam logic [6:0]  VSC_STEP_MAX   = 7'h7F;
   localparam logic [7:0]  VSC_PH_ALL     = 8'hFF;
   localparam logic [7:0]  VSC_PH_ONE     = 8'h01;
   localparam logic [7:0]  VSC_PH_TWO     = 8'h03;
   // ==========================================================
   // Timing
   localparam int VSC_MCLK_NS   = 25;
   localparam int VSC_WIN_NS    = 6400;
   localparam int VSC_WIN_CYC   = VSC_WIN_NS / VSC_MCLK_NS;
   localparam logic [7:0] VSC_WIN_LAST = 8'(VSC_WIN_CYC - 1);
   localparam logic [8:0] VSC_WIN_FULL = 9'(VSC_WIN_CYC);
   typedef enum logic [0:0] {VSC_ST_BOOT, VSC_ST_RUN} vsc_state_t;
endpackage

// *** design/vsc_slew.sv ***
// One-loop setpoint ramp, one unit per divider period
`timescale 1ns/1ps
`default_nettype none
module vsc_slew
   import vsc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Request
   input  wire logic [11:0] target,
   input  wire logic [11:0] div,
   // Ramp state
   output logic      [11:0] value,
   output logic             settled
);
   typedef struct packed {
      logic [11:0] val;
      logic [11:0] cnt;
   } vsc_slew_t;
   vsc_slew_t s_reg, s_next;

   // ==========================================================
   // Step toward target each time the divider expires
   always_comb
   begin
      s_next = s_reg;
      if (s_reg.val == target)
         s_next.cnt = 12'h000;
      else if (s_reg.cnt >= div)
      begin
         s_next.cnt = 12'h000;
         s_next.val = (s_reg.val < target) ? s_reg.val + 12'h001 : s_reg.val - 12'h001;
      end
      else
         s_next.cnt = s_reg.cnt + 12'h001;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign value   = s_reg.val;
   assign settled = (s_reg.val == target);

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_step_one;
      !$stable(value) |-> (value == $past(value) + 12'h001) || (value == $past(value) - 12'h001);
   endproperty
   a_step_one: assert property (p_step_one) else $error("ramp moved more than one unit");
   property p_step_spacing;
      (!$stable(value) && div >= 12'h001 && $stable(div)) |=> $stable(value);
   endproperty
   a_step_spacing: assert property (p_step_spacing) else $error("ramp ignored divider");
endmodule
`default_nettype wire

// *** design/vsc_duty_meter.sv ***
// Filtered duty-cycle measurement of the pulse-width voltage input
`timescale 1ns/1ps
`default_nettype none
module vsc_duty_meter
   import vsc_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Synchronised pin level
   input  wire logic       pwm_lvl,
   // Result
   output logic      [6:0] steps,
   output logic            idle
);
   typedef struct packed {
      logic [7:0] win;
      logic [8:0] hi;
      logic [6:0] last;
      logic [6:0] steps;
      logic       idle;
   } vsc_meter_t;
   vsc_meter_t m_reg, m_next;
   logic [8:0] total;
   logic [6:0] raw;

   // ==========================================================
   // Count high cycles per window, accept only results within one step, modulo 128, of the last window
   always_comb
   begin
      m_next = m_reg;
      total  = m_reg.hi + {8'h00, pwm_lvl};
      raw    = total[8] ? VSC_STEP_MAX : total[7:1];
      m_next.win = m_reg.win + 8'h01;
      m_next.hi  = total;
      if (m_reg.win == VSC_WIN_LAST)
      begin
         m_next.win  = 8'h00;
         m_next.hi   = 9'h000;
         m_next.last = raw;
         m_next.idle = (total == 9'h000) || (total == VSC_WIN_FULL);
         if ((raw - m_reg.last <= 7'h01) || (m_reg.last - raw <= 7'h01))
            m_next.steps = raw;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         m_reg <= '{win: 8'h00, hi: 9'h000, last: 7'h00, steps: 7'h00, idle: 1'b1};
      else
         m_reg <= m_next;
   end

   assign steps = m_reg.steps;
   assign idle  = m_reg.idle;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_steps_win;
      !$stable(steps) |-> $past(m_reg.win) == VSC_WIN_LAST;
   endproperty
   a_steps_win: assert property (p_steps_win) else $error("steps changed mid window");
endmodule
`default_nettype wire

// *** design/vsc_top.sv ***
// Voltage setpoint controller: serial voltage codes and pulse-width input
// ==========================================================
// Overview of operation
// - loop 1 serves core rail, loop 2 northbridge; one bit swaps them.
// - serial packet 8-bit code slews addressed loops at each loop's rate.
// - code decodes linearly, 6.25 mV down from 1.55 V; F6h is 12.5 mV.
// - off request ramps loop to zero and keeps power good asserted.
// - codes F7h to FFh mean off and report telemetry value 1F7h.
// - lowest nonzero setpoint is 12.5 mV; F7h never becomes a voltage.
// - pulse width sets output; step size is 5 mV or 10 mV.
// - standby high ramps to standby voltage; low resumes the pulse-width setpoint.
// - performance input high is normal, low is low-performance.
// - pulse-width power-on ramps to boot, then power good if above threshold.
// - pulse-width input not toggling returns output to boot voltage.
// - boot is 8-bit per loop in 5 mV or 10 mV steps.
// - pulse-width voltage is 0.6 V plus up to 127 steps.
// - configurable offset is added to the pulse-width setpoint.
// - low-performance drives first phase, optionally second, others off.
// - low-performance startup ramp takes eight times the turn-on time.
// - low-performance pulse-width changes slew eight times slower.
// - low-performance uses the low-power over-current limit register.
// - pulse-width setpoints clamp between 8-bit minimum and maximum.
// - serial codes act only with power-ok high; its fall returns to boot.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module vsc_top
   import vsc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Decoded serial voltage data packet
   input  wire logic        serial_voltage_data_valid,
   input  wire logic [7:0]  serial_voltage_data_code,
   input  wire logic        serial_voltage_data_core_sel,
   input  wire logic        serial_voltage_data_northbridge_rail_sel,
   // Pins
   input  wire logic        processor_power_ok,
   input  wire logic        pulse_width_voltage_input,
   input  wire logic        standby_input,
   input  wire logic        performance_level_input,
   // Telemetry values per loop
   output logic      [8:0]  serial_telemetry_return_l1,
   output logic      [8:0]  serial_telemetry_return_l2,
   // Regulation outputs
   output logic      [11:0] setpoint_l1,
   output logic      [11:0] setpoint_l2,
   output logic      [1:0]  loop_power_good_output,
   output logic      [7:0]  phase_enable,
   output logic      [7:0]  overcurrent_limit
);
   typedef struct packed {
      logic [1:0] pok_s;
      logic [1:0] stby_s;
      logic [1:0] perf_s;
      logic [1:0] pwm_s;
      logic [7:0] cfg;
      logic [7:0] boot1;
      logic [7:0] boot2;
      logic [7:0] stby;
      logic [7:0] vmin;
      logic [7:0] vmax;
      logic [7:0] offs;
      logic [7:0] rate1;
      logic [7:0] rate2;
      logic [7:0] tonr;
      logic [7:0] pgon;
      logic [7:0] ocn;
      logic [7:0] ocl;
      logic [7:0] rdata;
      vsc_state_t st;
      logic [11:0] tgt1;
      logic [11:0] tgt2;
      logic [8:0] tel1;
      logic [8:0] tel2;
      logic [1:0] pg;
      logic [7:0] phase;
      logic [7:0] oc;
      logic       pok_d;
   } vsc_top_t;
   vsc_top_t r_reg, r_next;

   logic [11:0] val1, val2, div1, div2, pwm_tgt;
   logic        set1, set2, pwm_idle, lp, res10, pwm_mode, hit1, hit2;
   logic [6:0]  steps;

   // ==========================================================
   // Helper functions
   // Scale an 8-bit code at 5 mV or 10 mV per step
   function automatic logic [11:0] scale8(input logic [7:0] v, input logic r10);
      scale8 = r10 ? {1'b0, v, 3'b000} : {2'b00, v, 2'b00};
   endfunction
   // Serial code to internal units
   function automatic logic [11:0] svid(input logic [7:0] c);
      svid = VSC_SVID_TOP - ({2'b00, c, 2'b00} + {4'h0, c});
   endfunction
   // Ramp divider, eight times longer when slowed
   function automatic logic [11:0] rdiv(input logic [7:0] rate, input logic slow);
      rdiv = slow ? {1'b0, rate, 3'b000} + 12'h007 : {4'h0, rate};
   endfunction

   // ==========================================================
   // Ramps and duty measurement
   vsc_slew u_slew1 (
      .mclk    (mclk),
      .rst     (rst),
      .target  (r_reg.tgt1),
      .div     (div1),
      .value   (val1),
      .settled (set1)
   );
   vsc_slew u_slew2 (
      .mclk    (mclk),
      .rst     (rst),
      .target  (r_reg.tgt2),
      .div     (div2),
      .value   (val2),
      .settled (set2)
   );
   vsc_duty_meter u_meter (
      .mclk    (mclk),
      .rst     (rst),
      .pwm_lvl (r_reg.pwm_s[1]),
      .steps   (steps),
      .idle    (pwm_idle)
   );

   // Mode decodes
   // low level is low-performance
   assign lp       = ~r_reg.perf_s[1];
   assign res10    = r_reg.cfg[VSC_CFG_RES10];
   assign pwm_mode = r_reg.cfg[VSC_CFG_PWM];

   // Ramp rates per state and mode
   // slowed startup ramp on both loops, slowed loop 1 transitions
   assign div1 = rdiv((r_reg.st == VSC_ST_BOOT) ? r_reg.tonr : r_reg.rate1, pwm_mode & lp);
   assign div2 = (r_reg.st == VSC_ST_BOOT) ? rdiv(r_reg.tonr, pwm_mode & lp)
                                           : rdiv(r_reg.rate2, 1'b0);

   // Pulse-width setpoint with offset and clamp
   always_comb
   begin
      pwm_tgt = VSC_PWM_BASE + scale8({1'b0, steps}, res10) + scale8(r_reg.offs, res10);
      if (pwm_tgt > scale8(r_reg.vmax, res10))
         pwm_tgt = scale8(r_reg.vmax, res10);
      if (pwm_tgt < scale8(r_reg.vmin, res10))
         pwm_tgt = scale8(r_reg.vmin, res10);
   end

   assign hit1 = r_reg.cfg[VSC_CFG_SWAP] ? serial_voltage_data_northbridge_rail_sel
                                         : serial_voltage_data_core_sel;
   assign hit2 = r_reg.cfg[VSC_CFG_SWAP] ? serial_voltage_data_core_sel
                                         : serial_voltage_data_northbridge_rail_sel;

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      r_next = r_reg;
      // Pin synchronisers
      r_next.pok_s  = {r_reg.pok_s[0], processor_power_ok};
      r_next.stby_s = {r_reg.stby_s[0], standby_input};
      r_next.perf_s = {r_reg.perf_s[0], performance_level_input};
      r_next.pwm_s  = {r_reg.pwm_s[0], pulse_width_voltage_input};
      r_next.pok_d  = r_reg.pok_s[1];
      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            VSC_REG_CFG:   r_next.cfg   = reg_wdata;
            VSC_REG_BOOT1: r_next.boot1 = reg_wdata;
            VSC_REG_BOOT2: r_next.boot2 = reg_wdata;
            VSC_REG_STBY:  r_next.stby  = reg_wdata;
            VSC_REG_VMIN:  r_next.vmin  = reg_wdata;
            VSC_REG_VMAX:  r_next.vmax  = reg_wdata;
            VSC_REG_OFFS:  r_next.offs  = reg_wdata;
            VSC_REG_RATE1: r_next.rate1 = reg_wdata;
            VSC_REG_RATE2: r_next.rate2 = reg_wdata;
            VSC_REG_TONR:  r_next.tonr  = reg_wdata;
            VSC_REG_PGON:  r_next.pgon  = reg_wdata;
            VSC_REG_OCN:   r_next.ocn   = reg_wdata;
            VSC_REG_OCL:   r_next.ocl   = reg_wdata;
            default:       r_next.cfg   = r_reg.cfg;
         endcase
      end
      // Register reads, data one cycle later
      r_next.rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            VSC_REG_CFG:    r_next.rdata = r_reg.cfg;
            VSC_REG_BOOT1:  r_next.rdata = r_reg.boot1;
            VSC_REG_BOOT2:  r_next.rdata = r_reg.boot2;
            VSC_REG_STBY:   r_next.rdata = r_reg.stby;
            VSC_REG_VMIN:   r_next.rdata = r_reg.vmin;
            VSC_REG_VMAX:   r_next.rdata = r_reg.vmax;
            VSC_REG_OFFS:   r_next.rdata = r_reg.offs;
            VSC_REG_RATE1:  r_next.rdata = r_reg.rate1;
            VSC_REG_RATE2:  r_next.rdata = r_reg.rate2;
            VSC_REG_TONR:   r_next.rdata = r_reg.tonr;
            VSC_REG_PGON:   r_next.rdata = r_reg.pgon;
            VSC_REG_OCN:    r_next.rdata = r_reg.ocn;
            VSC_REG_OCL:    r_next.rdata = r_reg.ocl;
            VSC_REG_STATUS: r_next.rdata = {r_reg.pg, lp, r_reg.stby_s[1], r_reg.pok_s[1],
                                            pwm_idle, set1 & set2,
                                            r_reg.st == VSC_ST_RUN};
            default:        r_next.rdata = 8'h00;
         endcase
      end
      r_next.phase = lp ? (r_reg.cfg[VSC_CFG_PH2] ? VSC_PH_TWO : VSC_PH_ONE) : VSC_PH_ALL;
      r_next.oc    = lp ? r_reg.ocl : r_reg.ocn;
      case (r_reg.st)
         VSC_ST_BOOT:
         begin
            r_next.tgt1 = scale8(r_reg.boot1, res10);
            r_next.tgt2 = scale8(r_reg.boot2, res10);
            if (set1 && set2 && r_reg.tgt1 == scale8(r_reg.boot1, res10)
                && r_reg.tgt2 == scale8(r_reg.boot2, res10))
            begin
               r_next.st = VSC_ST_RUN;
               r_next.pg[0] = !pwm_mode || (r_reg.boot1 > r_reg.pgon);
               r_next.pg[1] = !pwm_mode || (r_reg.boot2 > r_reg.pgon);
            end
         end
         VSC_ST_RUN:
         begin
            if (pwm_mode)
            begin
               if (r_reg.stby_s[1])
                  r_next.tgt1 = scale8(r_reg.stby, res10);
               else if (pwm_idle)
                  r_next.tgt1 = scale8(r_reg.boot1, res10);
               else
                  r_next.tgt1 = pwm_tgt;
            end
            else if (r_reg.pok_d && !r_reg.pok_s[1])
            begin
               r_next.tgt1 = scale8(r_reg.boot1, res10);
               r_next.tgt2 = scale8(r_reg.boot2, res10);
            end
            else if (serial_voltage_data_valid && r_reg.pok_s[1])
            begin
               if (hit1)
               begin
                  r_next.tgt1 = (serial_voltage_data_code >= VSC_OFF_CODE) ? 12'h000
                              : svid(serial_voltage_data_code);
                  r_next.tel1 = (serial_voltage_data_code >= VSC_OFF_CODE) ? VSC_TEL_OFF
                              : {1'b0, serial_voltage_data_code};
               end
               if (hit2)
               begin
                  r_next.tgt2 = (serial_voltage_data_code >= VSC_OFF_CODE) ? 12'h000
                              : svid(serial_voltage_data_code);
                  r_next.tel2 = (serial_voltage_data_code >= VSC_OFF_CODE) ? VSC_TEL_OFF
                              : {1'b0, serial_voltage_data_code};
               end
            end
         end
         default:
            r_next.st = VSC_ST_BOOT;
      endcase
   end

   // State register
   always_ff @(posedge mclk or posedge rst)
   begin
      // Performance synchroniser starts at the pin's idle high level
      if (rst)
         r_reg <= '{cfg: VSC_RST_CFG, boot1: VSC_RST_BOOT, boot2: VSC_RST_BOOT,
                    stby: VSC_RST_STBY, vmin: VSC_RST_VMIN, vmax: VSC_RST_VMAX,
                    offs: VSC_RST_OFFS, rate1: VSC_RST_RATE, rate2: VSC_RST_RATE,
                    tonr: VSC_RST_RATE, pgon: VSC_RST_PGON, ocn: VSC_RST_OC,
                    ocl: VSC_RST_OC, phase: VSC_PH_ALL, oc: VSC_RST_OC,
                    perf_s: 2'h3, st: VSC_ST_BOOT, default: '0};
      else
         r_reg <= r_next;
   end

   // Outputs
   assign reg_rdata                  = r_reg.rdata;
   assign serial_telemetry_return_l1 = r_reg.tel1;
   assign serial_telemetry_return_l2 = r_reg.tel2;
   assign setpoint_l1                = val1;
   assign setpoint_l2                = val2;
   assign loop_power_good_output     = r_reg.pg;
   assign phase_enable               = r_reg.phase;
   assign overcurrent_limit          = r_reg.oc;

   // ==========================================================
   // Checks
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_pkt1;
      r_reg.st == VSC_ST_RUN && !pwm_mode && r_reg.pok_d && r_reg.pok_s[1]
      && serial_voltage_data_valid && hit1;
   endsequence
   property p_map;
      s_pkt1 and (!r_reg.cfg[VSC_CFG_SWAP] && serial_voltage_data_code < VSC_OFF_CODE)
      |=> r_reg.tgt1 == svid($past(serial_voltage_data_code)) && $past(serial_voltage_data_core_sel);
   endproperty
   a_map: assert property (p_map) else $error("core code not applied to loop 1");
   property p_off;
      s_pkt1 and (serial_voltage_data_code >= VSC_OFF_CODE)
      |=> r_reg.tgt1 == 12'h000 && r_reg.tel1 == VSC_TEL_OFF;
   endproperty
   a_off: assert property (p_off) else $error("off code mishandled");
   property p_pg_hold;
      r_reg.st == VSC_ST_RUN |=> $stable(loop_power_good_output);
   endproperty
   a_pg_hold: assert property (p_pg_hold) else $error("power good dropped in run");
   property p_pok_fall;
      r_reg.st == VSC_ST_RUN && !pwm_mode && $fell(r_reg.pok_s[1]) && !reg_wr
      |=> r_reg.tgt1 == scale8(r_reg.boot1, res10);
   endproperty
   a_pok_fall: assert property (p_pok_fall) else $error("no boot after power-ok fall");
   property p_lp_phase;
      lp && !r_reg.cfg[VSC_CFG_PH2] && !reg_wr |=> phase_enable == VSC_PH_ONE;
   endproperty
   a_lp_phase: assert property (p_lp_phase) else $error("extra phases in low performance");
   property p_oc;
      lp |=> overcurrent_limit == $past(r_reg.ocl);
   endproperty
   a_oc: assert property (p_oc) else $error("wrong limit in low performance");
   property p_stby;
      r_reg.st == VSC_ST_RUN && pwm_mode && r_reg.stby_s[1] && !reg_wr
      |=> r_reg.tgt1 == scale8(r_reg.stby, res10);
   endproperty
   a_stby: assert property (p_stby) else $error("standby not applied");
   property p_idle;
      r_reg.st == VSC_ST_RUN && pwm_mode && !r_reg.stby_s[1] && pwm_idle && !reg_wr
      |=> r_reg.tgt1 == scale8(r_reg.boot1, res10);
   endproperty
   a_idle: assert property (p_idle) else $error("idle input not returned to boot");
   property p_clamp;
      r_reg.st == VSC_ST_RUN && pwm_mode && !r_reg.stby_s[1] && !pwm_idle && !reg_wr
      && r_reg.vmin <= r_reg.vmax
      |=> r_reg.tgt1 <= scale8(r_reg.vmax, res10) && r_reg.tgt1 >= scale8(r_reg.vmin, res10);
   endproperty
   a_clamp: assert property (p_clamp) else $error("setpoint outside min and max");
   c_off:   cover property (s_pkt1 and (serial_voltage_data_code == 8'hFF));
   c_run:   cover property (r_reg.st == VSC_ST_BOOT ##1 r_reg.st == VSC_ST_RUN);
   c_stby:  cover property (pwm_mode && $fell(r_reg.stby_s[1]));
   c_lp:    cover property (lp && pwm_mode && !set1);
endmodule
`default_nettype wire

// *** verif/vsc_gpu_model.sv ***
// Graphics processor model driving the pulse-width voltage pin
`timescale 1ns/1ps
`default_nettype none
module vsc_gpu_model
(
   // Clock and requested high time per window
   input  wire logic       mclk,
   input  wire logic [8:0] high_cyc,
   // Pin
   output logic            pwm_pin
);
   logic [7:0] cnt = 8'h00;
   // zero width: pin driven low throughout the window
   always @(posedge mclk)
   begin
      cnt     <= cnt + 8'h01;
      pwm_pin <= ({1'b0, cnt} < high_cyc);
   end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Testbench for the voltage setpoint controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vsc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  ra = 4'h0;
   logic [7:0]  wd = 8'h00;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        sv_v = 1'b0;
   logic [7:0]  sv_c = 8'h00;
   logic        sv_a = 1'b0;
   logic        sv_b = 1'b0;
   logic        stby = 1'b0;
   logic        perf = 1'b1;
   logic        pok = 1'b1;
   logic        pwm;
   logic [8:0]  hc = 9'h000;
   logic [7:0]  rdata;
   logic [7:0]  ph;
   logic [7:0]  oc;
   logic [8:0]  t1;
   logic [8:0]  t2;
   logic [11:0] s1;
   logic [11:0] s2;
   logic [1:0]  pg;
   int          err_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [11:0] rows [7] = '{12'h000, 12'h1B4, 12'h364, 12'h5FF, 12'hA3C, 12'hC80, 12'hE00};
   // ==========================================================
   // Clock, timeout and instances
   always #12.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_count++;
         end_sim();
      end
   end
   vsc_gpu_model u_vsc_gpu_model (.mclk(mclk), .high_cyc(hc), .pwm_pin(pwm));
   vsc_top u_vsc_top (.mclk(mclk), .rst(rst), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata(rdata), .serial_voltage_data_valid(sv_v),
      .serial_voltage_data_code(sv_c), .serial_voltage_data_core_sel(sv_a),
      .serial_voltage_data_northbridge_rail_sel(sv_b), .processor_power_ok(pok),
      .pulse_width_voltage_input(pwm), .standby_input(stby),
      .performance_level_input(perf), .serial_telemetry_return_l1(t1),
      .serial_telemetry_return_l2(t2), .setpoint_l1(s1), .setpoint_l2(s2),
      .loop_power_good_output(pg), .phase_enable(ph), .overcurrent_limit(oc));
   // ==========================================================
   // Bus and compare tasks
   task automatic chk(logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge mclk) {wr_s, ra, wd} <= {1'b1, a, d};
      @(posedge mclk) wr_s <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge mclk) {rd_s, ra} <= {1'b1, a};
      @(posedge mclk) rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic sv(logic [7:0] c, logic a, logic b, int n);
      @(posedge mclk) {sv_v, sv_c, sv_a, sv_b} <= {1'b1, c, a, b};
      @(posedge mclk) sv_v <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (5) @(posedge mclk);
      chk(ph, 8'hFF);
      rst <= 1'b0;
      foreach (rows[i]) rd(rows[i][11:8], rows[i][7:0]);
      repeat (3000) @(posedge mclk);
      chk(s1, 12'h2D0);
      sv(8'h00, 1'b1, 1'b0, 2200);
      chk({t1, s2}, 21'h0002D0);
      chk(s1, VSC_SVID_TOP);
      sv(8'hF7, 1'b0, 1'b1, 3000);
      chk(t2, VSC_TEL_OFF);
      chk({s2, pg}, 14'h0003);
      wr(VSC_REG_CFG, 8'h01);
      sv(8'hF6, 1'b1, 1'b0, 200);
      chk({t2, s2}, 21'h0F600A);
      // Power-ok fall: both loops back to boot, packets refused
      pok <= 1'b0;
      repeat (3000) @(posedge mclk);
      sv(8'h20, 1'b1, 1'b1, 4);
      chk({s1, s2}, 24'h2D02D0);
      chk({t1, t2}, 18'h000F6);
      pok <= 1'b1;
      wr(VSC_REG_CFG, 8'h04);
      hc <= 9'd100;
      repeat (3500) @(posedge mclk);
      chk(s1, 12'h2A8);
      wr(VSC_REG_OFFS, 8'h05);
      repeat (900) @(posedge mclk);
      chk(s1, 12'h2BC);
      wr(VSC_REG_VMAX, 8'hA0);
      repeat (900) @(posedge mclk);
      chk(s1, 12'h280);
      wr(VSC_REG_VMAX, 8'hFF);
      hc <= 9'h000;
      repeat (1500) @(posedge mclk);
      chk(s1, 12'h2D0);
      stby <= 1'b1;
      repeat (1600) @(posedge mclk);
      chk(s1, 12'h190);
      wr(VSC_REG_OCL, 8'h21);
      perf <= 1'b0;
      repeat (5) @(posedge mclk);
      chk({ph, oc}, 16'h0121);
      wr(VSC_REG_CFG, 8'h0C);
      repeat (2) @(posedge mclk);
      chk(ph, 8'h03);
      // Mid-run reset, then no false low-performance after release
      perf <= 1'b1;
      rst  <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({ph, oc, pg}, 18'h3FE00);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(ph, 8'hFF);
      end_sim();
   end
endmodule
`default_nettype wire
